// file: wdhw_pkg.sv
/*
  package for the watchdog and halt/wake-up block: register map, field layout,
  reset values, mode and state enumerations, timing constants.
  assumes an axi4-lite master with 32-bit data and one aligned word per register.
*/
package wdhw_pkg;
  localparam logic [3:0] WDHW_OFS_WDOG_CTRL = 4'h0;
  localparam logic [3:0] WDHW_OFS_RST_FLAGS = 4'h4;
  localparam logic [3:0] WDHW_OFS_PWR_CTRL = 4'h8;
  localparam logic [3:0] WDHW_OFS_STATUS = 4'hc;
  localparam logic [7:0] WDHW_WDOG_CTRL_RST = 8'h53;
  localparam logic [4:0] WDHW_KEY_A = 5'h15;
  localparam logic [4:0] WDHW_KEY_B = 5'h0a;
  localparam int WDHW_KEY_LSB = 3;
  localparam int WDHW_SRF_BIT = 0;
  localparam int WDHW_UVF_BIT = 2;
  localparam int WDHW_FKEEP_BIT = 1;
  localparam int WDHW_SKEEP_BIT = 0;
  localparam int WDHW_PORTA_WAKE_ENABLE_LSB = 8;
  localparam int WDHW_PORTA_W = 8;
  localparam int WDHW_CNT_W = 16;
  localparam logic [1:0] WDHW_RESP_OKAY = 2'b00;
  localparam logic [1:0] WDHW_RESP_SLVERR = 2'b10;
  localparam int WDHW_PRESCALE = 8;
  // soft reset delay in ns, default figure for simulation
  localparam int WDHW_SRESET_NS = 100;
  localparam int WDHW_CLK_NS = 10;
  localparam int WDHW_SRESET_CYC = (WDHW_SRESET_NS + WDHW_CLK_NS - 1) / WDHW_CLK_NS;

  typedef enum logic [2:0] {
    WDHW_RUN, WDHW_SLEEP, WDHW_IDLE_SLOW_ONLY, WDHW_IDLE_BOTH_CLOCKS, WDHW_IDLE_FAST_ONLY
  } wdhw_mode_t;

  typedef enum logic [1:0] {
    WDHW_RESUME_NONE, WDHW_RESUME_NEXT, WDHW_RESUME_VECTOR, WDHW_RESUME_PCSP
  } wdhw_resume_t;

  typedef struct packed {
    logic halt;
    logic clear_watchdog_instr;
    logic int_req;
    logic int_enabled;
    logic stack_full;
  } wdhw_core_in_t;

  typedef struct packed {
    logic fast_clk_en;
    logic slow_clk_en;
    logic cpu_stall;
  } wdhw_clk_out_t;
endpackage : wdhw_pkg

// file: wdhw_top.sv
/*
  watchdog timer with halt, power-down and wake-up control.
  assumes one 100 MHz clock, a slow-oscillator tick input already in this domain,
  port a pins from outside (synchronised here), and core strobes on this clock.
*/
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
module wdhw_top
  import wdhw_pkg::*;
#(
  parameter int SRESET_CYC = WDHW_SRESET_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slow_osc_tick,
  input wire logic undervoltage_event,
  input wire wdhw_core_in_t core_in,
  input wire logic [WDHW_PORTA_W-1:0] porta_pins,
  output wdhw_clk_out_t clk_out,
  output wdhw_resume_t resume,
  output logic device_reset,
  output logic power_down_flag,
  output logic wdog_expiry_flag
);
  // axi slave state
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  // block state
  logic [7:0] watchdog_control_reg;
  logic soft_reset_flag_reg, undervoltage_reset_flag_reg;
  logic [1:0] system_clock_control_reg;
  logic [WDHW_PORTA_W-1:0] porta_wake_enable_reg;
  logic [WDHW_PORTA_W-1:0] pa_s1_reg, pa_s2_reg, pa_s3_reg, pa_level_reg;
  logic [2:0] presc_reg;
  logic [WDHW_CNT_W-1:0] cnt_reg;
  logic [15:0] srst_cnt_reg;
  logic srst_pend_reg, int_masked_reg, pdf_reg, to_reg, dev_rst_reg;
  wdhw_resume_t resume_reg;
  wdhw_mode_t mode_reg, mode_next;

  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_ctrl = do_write && awaddr_reg == WDHW_OFS_WDOG_CTRL && wstrb_reg[0];
  wire wr_flags = do_write && awaddr_reg == WDHW_OFS_RST_FLAGS && wstrb_reg[0];
  wire wr_pwr = do_write && awaddr_reg == WDHW_OFS_PWR_CTRL;
  wire wr_ok = awaddr_reg == WDHW_OFS_WDOG_CTRL || awaddr_reg == WDHW_OFS_RST_FLAGS
    || awaddr_reg == WDHW_OFS_PWR_CTRL || awaddr_reg == WDHW_OFS_STATUS;
  wire [4:0] new_key = wdata_reg[WDHW_KEY_LSB +: 5];
  wire key_bad = wr_ctrl && new_key != WDHW_KEY_A && new_key != WDHW_KEY_B;
  wire asleep = mode_reg != WDHW_RUN;
  wire halt_go = core_in.halt && !asleep;
  wire div_tick = slow_osc_tick && presc_reg == 3'(WDHW_PRESCALE - 1);

  // threshold per period code; a lookup keeps the exponents visible
  logic [4:0] period_exp;
  always_comb begin
    case (watchdog_control_reg[2:0])
      3'h0: period_exp = 5'h05;
      3'h1: period_exp = 5'h07;
      3'h2: period_exp = 5'h09;
      3'h3: period_exp = 5'h0b;
      3'h4: period_exp = 5'h0c;
      3'h5: period_exp = 5'h0d;
      3'h6: period_exp = 5'h0e;
      default: period_exp = 5'h0f;
    endcase
  end
  wire [WDHW_CNT_W:0] limit = (WDHW_CNT_W+1)'(1) << period_exp;
  wire overflow = div_tick && ((WDHW_CNT_W+1)'(cnt_reg) + 1'b1 == limit);
  wire cnt_clear = key_bad || core_in.clear_watchdog_instr || halt_go;

  // pin falling edge, counted once stages two and three agree
  wire [WDHW_PORTA_W-1:0] pa_stable = ~(pa_s2_reg ^ pa_s3_reg);
  wire [WDHW_PORTA_W-1:0] pa_fall = pa_stable & pa_level_reg & ~pa_s3_reg;
  wire pin_wake = |(pa_fall & porta_wake_enable_reg);
  wire int_wake = core_in.int_req && !int_masked_reg;

  // mode chosen from the two keep bits at halt
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      WDHW_RUN: begin
        if (halt_go) begin
          case (system_clock_control_reg)
            2'b00: mode_next = WDHW_SLEEP;
            2'b01: mode_next = WDHW_IDLE_SLOW_ONLY;
            2'b11: mode_next = WDHW_IDLE_BOTH_CLOCKS;
            default: mode_next = WDHW_IDLE_FAST_ONLY;
          endcase
        end
      end
      default: begin
        if (overflow || pin_wake || int_wake) begin
          mode_next = WDHW_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= WDHW_RUN;
    end else if (clk_en) begin
      mode_reg <= mode_next;
    end
  end

  // where the core resumes after a wake
  wdhw_resume_t resume_next;
  always_comb begin
    resume_next = WDHW_RESUME_NONE;
    if (asleep && overflow) begin
      resume_next = WDHW_RESUME_PCSP;
    end else if (asleep && int_wake && core_in.int_enabled && !core_in.stack_full) begin
      resume_next = WDHW_RESUME_VECTOR;
    end else if (asleep && (int_wake || pin_wake)) begin
      resume_next = WDHW_RESUME_NEXT;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg <= 3'h0;
      cnt_reg <= '0;
      resume_reg <= WDHW_RESUME_NONE;
      int_masked_reg <= 1'b0;
    end else if (clk_en) begin
      if (slow_osc_tick) begin
        presc_reg <= presc_reg + 3'h1;
      end
      // counting continues in every mode, sleep included
      if (cnt_clear || overflow) begin
        cnt_reg <= '0;
      end else if (div_tick) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      resume_reg <= resume_next;
      if (halt_go) begin
        int_masked_reg <= core_in.int_req;
      end else if (!asleep) begin
        int_masked_reg <= 1'b0;
      end
    end
  end

  // flags, soft reset delay and device reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pdf_reg <= 1'b0;
      to_reg <= 1'b0;
      soft_reset_flag_reg <= 1'b0;
      undervoltage_reset_flag_reg <= 1'b0;
      srst_pend_reg <= 1'b0;
      srst_cnt_reg <= 16'h0000;
      dev_rst_reg <= 1'b0;
    end else if (clk_en) begin
      dev_rst_reg <= 1'b0;
      if (halt_go) begin
        pdf_reg <= 1'b1;
        to_reg <= 1'b0;
      end else if (core_in.clear_watchdog_instr) begin
        pdf_reg <= 1'b0;
      end
      if (overflow) begin
        to_reg <= 1'b1;
        dev_rst_reg <= !asleep;
      end
      if (key_bad) begin
        srst_pend_reg <= 1'b1;
        srst_cnt_reg <= 16'(SRESET_CYC);
      end else if (srst_pend_reg) begin
        if (srst_cnt_reg == 16'h0001) begin
          srst_pend_reg <= 1'b0;
          dev_rst_reg <= 1'b1;
        end
        srst_cnt_reg <= srst_cnt_reg - 16'h0001;
      end
      // hardware set wins over a software clear in the same cycle
      if (srst_pend_reg && srst_cnt_reg == 16'h0001) begin
        soft_reset_flag_reg <= 1'b1;
      end else if (wr_flags && !wdata_reg[WDHW_SRF_BIT]) begin
        soft_reset_flag_reg <= 1'b0;
      end
      if (undervoltage_event) begin
        undervoltage_reset_flag_reg <= 1'b1;
      end else if (wr_flags && !wdata_reg[WDHW_UVF_BIT]) begin
        undervoltage_reset_flag_reg <= 1'b0;
      end
    end
  end

  // port a synchroniser: stage one feeds only stage two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_s1_reg <= '1;
      pa_s2_reg <= '1;
      pa_s3_reg <= '1;
      pa_level_reg <= '1;
    end else if (clk_en) begin
      pa_s1_reg <= porta_pins;
      pa_s2_reg <= pa_s1_reg;
      pa_s3_reg <= pa_s2_reg;
      for (int i = 0; i < WDHW_PORTA_W; i++) begin
        if (pa_stable[i]) begin
          pa_level_reg[i] <= pa_s3_reg[i];
        end
      end
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_control_reg <= WDHW_WDOG_CTRL_RST;
      system_clock_control_reg <= 2'b00;
      porta_wake_enable_reg <= '0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        watchdog_control_reg <= wdata_reg[7:0];
      end
      if (wr_pwr && wstrb_reg[0]) begin
        system_clock_control_reg <= wdata_reg[1:0];
      end
      if (wr_pwr && wstrb_reg[1]) begin
        porta_wake_enable_reg <= wdata_reg[WDHW_PORTA_WAKE_ENABLE_LSB +: WDHW_PORTA_W];
      end
    end
  end

  // axi4-lite slave: address and data taken in either order, one write at a time
  wire [31:0] rd_mux =
    (s_axi_araddr == WDHW_OFS_WDOG_CTRL) ? {24'h0, watchdog_control_reg} :
    (s_axi_araddr == WDHW_OFS_RST_FLAGS) ?
      {29'h0, undervoltage_reset_flag_reg, 1'b0, soft_reset_flag_reg} :
    (s_axi_araddr == WDHW_OFS_PWR_CTRL) ?
      {16'h0, porta_wake_enable_reg, 6'h00, system_clock_control_reg} :
    {24'h0, 1'b0, mode_reg, 2'b00, to_reg, pdf_reg};
  wire rd_ok = s_axi_araddr == WDHW_OFS_WDOG_CTRL || s_axi_araddr == WDHW_OFS_RST_FLAGS
    || s_axi_araddr == WDHW_OFS_PWR_CTRL || s_axi_araddr == WDHW_OFS_STATUS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bresp_reg <= WDHW_RESP_OKAY;
      rresp_reg <= WDHW_RESP_OKAY;
      rdata_reg <= 32'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? WDHW_RESP_OKAY : WDHW_RESP_SLVERR;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_ok ? rd_mux : 32'h0;
        rresp_reg <= rd_ok ? WDHW_RESP_OKAY : WDHW_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready = clk_en && !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = clk_en && !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = clk_en && !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // stalled in every power-down mode; the watchdog alone runs in sleep
  assign clk_out.cpu_stall = asleep;
  assign clk_out.fast_clk_en = mode_reg == WDHW_RUN || mode_reg == WDHW_IDLE_BOTH_CLOCKS
    || mode_reg == WDHW_IDLE_FAST_ONLY;
  assign clk_out.slow_clk_en = mode_reg == WDHW_RUN || mode_reg == WDHW_IDLE_BOTH_CLOCKS
    || mode_reg == WDHW_IDLE_SLOW_ONLY;
  assign resume = resume_reg;
  assign device_reset = dev_rst_reg;
  assign power_down_flag = pdf_reg;
  assign wdog_expiry_flag = to_reg;

  property p_halt_flags;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && halt_go) |=> (pdf_reg && !to_reg && asleep);
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");

  property p_idle_slow;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && halt_go && system_clock_control_reg == 2'b01)
        |=> (!clk_out.fast_clk_en && clk_out.slow_clk_en && clk_out.cpu_stall);
  endproperty
  a_idle_slow: assert property (p_idle_slow) else $error("idle slow clocks wrong");

  property p_idle_both;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && halt_go && system_clock_control_reg == 2'b11)
        |=> (clk_out.fast_clk_en && clk_out.slow_clk_en && clk_out.cpu_stall);
  endproperty
  a_idle_both: assert property (p_idle_both) else $error("idle both clocks wrong");

  property p_idle_fast;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && halt_go && system_clock_control_reg == 2'b10)
        |=> (clk_out.fast_clk_en && !clk_out.slow_clk_en);
  endproperty
  a_idle_fast: assert property (p_idle_fast) else $error("idle fast clocks wrong");

  property p_sleep;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && halt_go && system_clock_control_reg == 2'b00)
        |=> (!clk_out.fast_clk_en && !clk_out.slow_clk_en);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");

  property p_cnt_clear;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && cnt_clear) |=> cnt_reg == '0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");

  property p_wdt_wake;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && asleep && overflow)
        |=> (!asleep && to_reg && resume == WDHW_RESUME_PCSP && !device_reset);
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

  property p_run_timeout;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && !asleep && overflow) |=> (device_reset && to_reg);
  endproperty
  a_run_timeout: assert property (p_run_timeout) else $error("run timeout wrong");

  property p_srf_sticky;
    @(posedge aclk) disable iff (!aresetn)
      (soft_reset_flag_reg && !(clk_en && wr_flags)) |=> soft_reset_flag_reg;
  endproperty
  a_srf_sticky: assert property (p_srf_sticky) else $error("soft flag lost");

  property p_pin_wake;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && asleep && pin_wake && !overflow && !int_wake)
        |=> (!asleep && resume == WDHW_RESUME_NEXT);
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin wake wrong");
endmodule : wdhw_top

// file: wdhw_top_tb.sv
/*
  self-checking bench for the watchdog and halt/wake-up block.
  assumes wdhw_pkg and wdhw_top are compiled first; the bench drives every port itself.
*/
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module wdhw_top_tb;
  import wdhw_pkg::*;
  // a long soft-reset delay keeps the pulse from landing before the write task returns
  localparam int SRST = 20;
  localparam int TICK_CYC = 2 * WDHW_PRESCALE;
  localparam int SLACK = 3 * TICK_CYC;
  localparam int T0 = 32 * TICK_CYC;
  localparam int T1 = 128 * TICK_CYC;
  localparam logic [4:0] M_HALT = 5'b10000;
  localparam logic [4:0] M_CLR = 5'b01000;
  localparam logic [4:0] M_INT = 5'b00100;
  logic aclk, aresetn, clk_en;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, rs;
  logic slow_osc_tick, tick_on, undervoltage_event;
  wdhw_core_in_t core_in;
  logic [WDHW_PORTA_W-1:0] porta_pins;
  wdhw_clk_out_t clk_out;
  wdhw_resume_t resume, v;
  logic device_reset, power_down_flag, wdog_expiry_flag;
  int errors, compares, c;
  logic [2:0] mode_tab [4] = '{3'd1, 3'd2, 3'd4, 3'd3};
  logic [2:0] clk_tab [4] = '{3'b001, 3'b011, 3'b101, 3'b111};
  logic [1:0] ie_tab [3] = '{2'b10, 2'b00, 2'b11};
  wdhw_resume_t res_tab [3] = '{WDHW_RESUME_VECTOR, WDHW_RESUME_NEXT, WDHW_RESUME_NEXT};

  wdhw_top #(.SRESET_CYC(SRST)) u_wdhw_top (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .slow_osc_tick(slow_osc_tick), .undervoltage_event(undervoltage_event),
    .core_in(core_in), .porta_pins(porta_pins), .clk_out(clk_out), .resume(resume),
    .device_reset(device_reset), .power_down_flag(power_down_flag),
    .wdog_expiry_flag(wdog_expiry_flag)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // slow oscillator stand-in: one-cycle pulse every second clock while enabled
  always @(posedge aclk) begin
    slow_osc_tick <= tick_on & ~slow_osc_tick;
  end

  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic timeout;
    errors++;
    $display("mismatch %s expected %s seen %s", "wait", "event", "timeout");
    give_verdict();
  endtask : timeout

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    bit aw, w, b;
    int k;
    aw = 0;
    w = 0;
    b = 0;
    k = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && k < 50) begin
      @(negedge aclk);
      aw = awvalid && (awready === 1'b1);
      w = wvalid && (wready === 1'b1);
      b = (bvalid === 1'b1);
      if (b) `CHK("bresp", WDHW_RESP_OKAY, bresp)
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      k++;
    end
    if (!b) timeout();
    // one idle edge, so back-to-back calls never drive a signal twice in one step
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar, rv;
    int k;
    ar = 0;
    rv = 0;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rv && k < 50) begin
      @(negedge aclk);
      ar = arvalid && (arready === 1'b1);
      rv = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      if (rv) rready <= 1'b0;
      k++;
    end
    if (!rv) timeout();
    @(posedge aclk);
  endtask : axi_read

  // per-field drives, so core_in fields set in the same step are not overwritten
  task automatic core_pulse(input logic [4:0] m);
    if (m[4]) core_in.halt <= 1'b1;
    if (m[3]) core_in.clear_watchdog_instr <= 1'b1;
    if (m[2]) core_in.int_req <= 1'b1;
    @(posedge aclk);
    if (m[4]) core_in.halt <= 1'b0;
    if (m[3]) core_in.clear_watchdog_instr <= 1'b0;
    if (m[2]) core_in.int_req <= 1'b0;
  endtask : core_pulse

  // sel 0 waits for device_reset, sel 1 for a resume code; checks the delay window
  task automatic wait_evt(input bit sel, input int lo, input int hi, output wdhw_resume_t val);
    bit hit;
    c = 0;
    hit = 0;
    while (!hit && c <= hi) begin
      @(negedge aclk);
      hit = sel ? (resume !== WDHW_RESUME_NONE) : (device_reset === 1'b1);
      val = resume;
      if (!hit) c++;
    end
    if (!hit) timeout();
    `CHK("event delay in window", 1'b1, (c >= lo && c <= hi))
    @(posedge aclk);
  endtask : wait_evt

  initial begin
    aresetn = 1'b0;
    clk_en = 1'b1;
    {awaddr, araddr, wstrb, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    tick_on = 1'b0;
    undervoltage_event = 1'b0;
    core_in = '0;
    porta_pins = '1;
    errors = 0;
    compares = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(WDHW_OFS_WDOG_CTRL, rd, rs);
    `CHK("ctrl reset", {24'h0, WDHW_WDOG_CTRL_RST}, rd)
    axi_read(WDHW_OFS_RST_FLAGS, rd, rs);
    `CHK("soft flag reset", 1'b0, rd[WDHW_SRF_BIT])
    `CHK("pdf reset", 1'b0, power_down_flag)
    axi_read(4'h2, rd, rs);
    `CHK("unmapped resp", WDHW_RESP_SLVERR, rs)
    `CHK("unmapped data", 32'h0, rd)
    // timeout while running, shortest period
    axi_write(WDHW_OFS_WDOG_CTRL, {24'h0, WDHW_KEY_A, 3'b000});
    core_pulse(M_CLR);
    tick_on <= 1'b1;
    wait_evt(1'b0, T0 - SLACK, T0 + SLACK, v);
    tick_on <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK("expiry after run timeout", 1'b1, wdog_expiry_flag)
    // a clear part-way restarts the count
    axi_write(WDHW_OFS_WDOG_CTRL, {24'h0, WDHW_KEY_A, 3'b000});
    core_pulse(M_CLR);
    tick_on <= 1'b1;
    repeat (T0 - 4 * TICK_CYC) @(posedge aclk);
    core_pulse(M_CLR);
    wait_evt(1'b0, T0 - SLACK, T0 + SLACK, v);
    tick_on <= 1'b0;
    // second period code with the other valid key
    axi_write(WDHW_OFS_WDOG_CTRL, {24'h0, WDHW_KEY_B, 3'b001});
    core_pulse(M_CLR);
    tick_on <= 1'b1;
    wait_evt(1'b0, T1 - SLACK, T1 + SLACK, v);
    tick_on <= 1'b0;
    // invalid key: delayed reset and sticky soft flag
    axi_write(WDHW_OFS_WDOG_CTRL, {24'h0, 5'h1f, 3'b011});
    wait_evt(1'b0, SRST - 8, SRST + 4, v);
    axi_write(WDHW_OFS_WDOG_CTRL, {24'h0, WDHW_WDOG_CTRL_RST});
    undervoltage_event <= 1'b1;
    @(posedge aclk);
    undervoltage_event <= 1'b0;
    axi_read(WDHW_OFS_RST_FLAGS, rd, rs);
    `CHK("soft flag set", 1'b1, rd[WDHW_SRF_BIT])
    `CHK("undervoltage flag set", 1'b1, rd[WDHW_UVF_BIT])
    axi_write(WDHW_OFS_RST_FLAGS, 32'h0);
    axi_read(WDHW_OFS_RST_FLAGS, rd, rs);
    `CHK("soft flag cleared", 1'b0, rd[WDHW_SRF_BIT])
    `CHK("undervoltage flag cleared", 1'b0, rd[WDHW_UVF_BIT])
    // each halt mode, an unenabled pin that must not wake, then an enabled pin
    for (int k = 0; k < 4; k++) begin
      axi_write(WDHW_OFS_PWR_CTRL, {16'h0, 8'h04, 6'h0, 2'(k)});
      core_pulse(M_HALT);
      repeat (2) @(posedge aclk);
      axi_read(WDHW_OFS_STATUS, rd, rs);
      `CHK("status in halt", {25'h0, mode_tab[k], 4'b0001}, rd)
      `CHK("clocks in halt", clk_tab[k], clk_out)
      `CHK("expiry cleared", 1'b0, wdog_expiry_flag)
      porta_pins <= 8'hdf;
      repeat (8) @(posedge aclk);
      `CHK("stall on unenabled pin", 1'b1, clk_out.cpu_stall)
      porta_pins <= 8'hdb;
      wait_evt(1'b1, 0, 10, v);
      `CHK("pin wake resume", WDHW_RESUME_NEXT, v)
      porta_pins <= '1;
      repeat (2) @(posedge aclk);
      `CHK("running after wake", 3'b110, clk_out)
      core_pulse(M_CLR);
      repeat (2) @(posedge aclk);
      `CHK("pdf cleared", 1'b0, power_down_flag)
    end
    // interrupt wake: enabled with room, disabled, enabled with full stack
    for (int j = 0; j < 3; j++) begin
      core_in.int_enabled <= ie_tab[j][1];
      core_in.stack_full <= ie_tab[j][0];
      core_pulse(M_HALT);
      repeat (3) @(posedge aclk);
      core_pulse(M_INT);
      wait_evt(1'b1, 0, 4, v);
      `CHK("interrupt wake resume", res_tab[j], v)
    end
    core_in.stack_full <= 1'b0;
    // request already pending before the halt is no wake-up source
    core_in.int_req <= 1'b1;
    @(posedge aclk);
    core_pulse(M_HALT);
    repeat (10) @(posedge aclk);
    `CHK("stall with stale request", 1'b1, clk_out.cpu_stall)
    porta_pins <= 8'hfb;
    wait_evt(1'b1, 0, 10, v);
    `CHK("pin wake after stale request", WDHW_RESUME_NEXT, v)
    porta_pins <= '1;
    core_in.int_req <= 1'b0;
    // overflow in sleep; the halt alone clears the count
    axi_write(WDHW_OFS_PWR_CTRL, 32'h0);
    axi_write(WDHW_OFS_WDOG_CTRL, {24'h0, WDHW_KEY_A, 3'b000});
    tick_on <= 1'b1;
    // half a period of counting first, so only the halt's clear keeps the window
    repeat (T0 / 2) @(posedge aclk);
    core_pulse(M_HALT);
    wait_evt(1'b1, T0 - SLACK, T0 + SLACK, v);
    tick_on <= 1'b0;
    `CHK("overflow wake resume", WDHW_RESUME_PCSP, v)
    repeat (2) @(posedge aclk);
    `CHK("expiry after sleep overflow", 1'b1, wdog_expiry_flag)
    `CHK("pdf kept after sleep overflow", 1'b1, power_down_flag)
    // clock enable low: a clear strobe must not reach the frozen flag
    clk_en <= 1'b0;
    core_pulse(M_CLR);
    repeat (2) @(posedge aclk);
    `CHK("pdf frozen", 1'b1, power_down_flag)
    `CHK("awready frozen", 1'b0, awready)
    clk_en <= 1'b1;
    give_verdict();
  end
endmodule : wdhw_top_tb
